// [core/bmc_pkg.sv]
// package: register map, field layout and reset values of the bias and mux control bank
package bmc_pkg;
    localparam logic [3:0] BMC_ADDR_BIAS = 4'h1;
    localparam logic [3:0] BMC_ADDR_MUX_CONTROL_ONE = 4'h2;
    localparam logic [7:0] BMC_BIAS_RST = 8'h00;
    localparam logic [6:0] BMC_MUX_CONTROL_ONE_RST = 7'h00;
    localparam int BMC_CLKSRC_BIT = 7;
    localparam logic [2:0] BMC_MON_NORMAL = 3'h0;
    localparam logic [3:0] BMC_WRITE_REGISTER_COMMAND_OP = 4'h4;
    localparam logic [3:0] BMC_RREG_OP = 4'h2;
    localparam logic [3:0] BMC_UPPER_ZERO = 4'h0;
    localparam logic [7:0] BMC_NOP = 8'hff;
    localparam logic [3:0] BMC_CNT_ZERO = 4'h0;

    typedef enum logic [1:0] {
        BMC_IDLE = 2'b00,
        BMC_COUNT = 2'b01,
        BMC_WDATA = 2'b11,
        BMC_RDATA = 2'b10
    } bmc_state_e;

    typedef struct packed {
        logic [1:0] ref_ctrl;
        logic [1:0] ref_sel;
        logic [2:0] mon_sel;
    } bmc_mux_control_one_s;

    typedef struct packed {
        bmc_state_e state;
        logic [3:0] addr;
        logic [3:0] count;
        logic [7:0] bias;
        bmc_mux_control_one_s mux_control_one;
        logic [7:0] bias_out;
        logic clk_src;
        logic [7:0] rd_data;
        logic rd_valid;
    } bmc_regs_s;
endpackage : bmc_pkg

// [core/bmc_regs.sv]
// bias enable and second mux control registers behind a byte command port
`timescale 1ns/100ps
// How it works
// - Bias output bit n drives the mid-supply bias switch of input n while enable bit n is one.
// - A zero enable bit leaves that input unbiased, and all enable bits clear on reset.
// - The second mux control register sits at address 02h with its low seven bits reset to zero.
// - Bit 7 of that register is a read-only clock source flag that writes cannot change.
// - The flag reads zero on the internal oscillator and one on an external clock.
// - Any nonzero monitor select removes all input bias, only 000 keeps normal routing.
module bmc_regs
    import bmc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // command byte stream from the serial front end
    input wire logic [7:0] cmd_byte_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_end_i,
    // clock source in use: 0 internal oscillator, 1 external
    input wire logic ext_clk_sel_i,
    // read data back to the serial front end
    output logic [7:0] rd_byte_o,
    output logic rd_valid_o,
    // analog controls
    output logic [7:0] bias_en_o,
    output logic [1:0] ref_ctrl_o,
    output logic [1:0] ref_sel_o,
    output logic [2:0] mon_sel_o
);
    bmc_regs_s r;
    bmc_regs_s next_r;
    // an end in the same cycle as a byte wins, so the byte is never taken
    logic cmd_take;
    assign cmd_take = cmd_valid_i && !cmd_end_i;

    function automatic logic [7:0] read_reg(input bmc_regs_s s, input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == BMC_ADDR_BIAS) begin
            v = s.bias;
        end else if (a == BMC_ADDR_MUX_CONTROL_ONE) begin
            v = {s.clk_src, s.mux_control_one};
        end
        return v;
    endfunction : read_reg

    always_comb begin
        next_r = r;
        next_r.rd_valid = 1'b0;
        next_r.clk_src = ext_clk_sel_i;
        case (r.state)
            BMC_IDLE: begin
                if (cmd_take && cmd_byte_i[7:4] == BMC_WRITE_REGISTER_COMMAND_OP) begin
                    next_r.addr = cmd_byte_i[3:0];
                    next_r.state = BMC_COUNT;
                    next_r.count = BMC_CNT_ZERO;
                end else if (cmd_take && cmd_byte_i[7:4] == BMC_RREG_OP) begin
                    next_r.addr = cmd_byte_i[3:0];
                    next_r.state = BMC_COUNT;
                    next_r.count = 4'hf;
                end
            end
            BMC_COUNT: begin
                if (cmd_take) begin
                    // count byte marked in count field: f means read pending
                    if (r.count == 4'hf) begin
                        next_r.state = BMC_RDATA;
                    end else begin
                        next_r.state = BMC_WDATA;
                    end
                    next_r.count = cmd_byte_i[3:0];
                end
            end
            BMC_WDATA: begin
                if (cmd_take) begin
                    // writes to unlisted addresses are dropped, this bank owns two only
                    if (r.addr == BMC_ADDR_BIAS) begin
                        next_r.bias = cmd_byte_i;
                    end else if (r.addr == BMC_ADDR_MUX_CONTROL_ONE) begin
                        next_r.mux_control_one = cmd_byte_i[BMC_CLKSRC_BIT-1:0];
                    end
                    next_r.addr = r.addr + 4'h1;
                    next_r.count = r.count - 4'h1;
                    if (r.count == BMC_CNT_ZERO) begin
                        next_r.state = BMC_IDLE;
                    end
                end
            end
            BMC_RDATA: begin
                // any byte clocks out data; its content is ignored as a command
                if (cmd_take) begin
                    next_r.rd_data = read_reg(r, r.addr);
                    next_r.rd_valid = 1'b1;
                    next_r.addr = r.addr + 4'h1;
                    next_r.count = r.count - 4'h1;
                    if (r.count == BMC_CNT_ZERO) begin
                        next_r.state = BMC_IDLE;
                    end
                end
            end
            default: begin
                next_r.state = BMC_IDLE;
            end
        endcase
        if (cmd_end_i) begin
            next_r.state = BMC_IDLE;
        end
        // monitor modes disconnect the inputs, so no bias may reach them
        if (next_r.mux_control_one.mon_sel != BMC_MON_NORMAL) begin
            next_r.bias_out = 8'h00;
        end else begin
            next_r.bias_out = next_r.bias;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            r.state <= BMC_IDLE;
            r.addr <= BMC_CNT_ZERO;
            r.count <= BMC_CNT_ZERO;
            r.bias <= BMC_BIAS_RST;
            r.mux_control_one <= BMC_MUX_CONTROL_ONE_RST;
            r.bias_out <= BMC_BIAS_RST;
            r.clk_src <= 1'b0;
            r.rd_data <= 8'h00;
            r.rd_valid <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign rd_byte_o = r.rd_data;
    assign rd_valid_o = r.rd_valid;
    assign bias_en_o = r.bias_out;
    assign ref_ctrl_o = r.mux_control_one.ref_ctrl;
    assign ref_sel_o = r.mux_control_one.ref_sel;
    assign mon_sel_o = r.mux_control_one.mon_sel;

    a_bias_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.mux_control_one.mon_sel == BMC_MON_NORMAL) |-> (bias_en_o == r.bias))
        else $error("bias output differs from enable register");
    a_bias_reset: assert property (@(posedge sys_clk_i)
        sys_rst_i |=> (r.bias == 8'h00 && bias_en_o == 8'h00))
        else $error("bias not cleared by reset");
    a_mux_control_one_reset: assert property (@(posedge sys_clk_i)
        sys_rst_i |=> (r.mux_control_one == 7'h00))
        else $error("mux control not cleared by reset");
    a_flag_readonly: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rd_valid_o && $past(r.addr) == BMC_ADDR_MUX_CONTROL_ONE) |-> rd_byte_o[7] == $past(r.clk_src))
        else $error("clock flag read wrong");
    a_flag_source: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ##1 r.clk_src == $past(ext_clk_sel_i))
        else $error("clock flag does not track source");
    a_fields_out: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        {ref_ctrl_o, ref_sel_o, mon_sel_o} == r.mux_control_one)
        else $error("field outputs mismatch");
    a_monitor_kill: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (mon_sel_o != BMC_MON_NORMAL) |-> (bias_en_o == 8'h00))
        else $error("bias present in monitor mode");
    a_write_register_command_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_IDLE && cmd_valid_i && !cmd_end_i && cmd_byte_i[7:4] == BMC_WRITE_REGISTER_COMMAND_OP)
        |=> (r.state == BMC_COUNT && r.addr == $past(cmd_byte_i[3:0])))
        else $error("write command not accepted");

    // command sequencing and data paths
    a_end_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_end_i
        |=> (r.state == BMC_IDLE))
        else $error("end did not return to idle");
    a_abort_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cmd_end_i
        |=> (r.bias == $past(r.bias) && r.mux_control_one == $past(r.mux_control_one)))
        else $error("aborted byte changed a register");
    a_bias_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_WDATA && cmd_take && r.addr == BMC_ADDR_BIAS)
        |=> (r.bias == $past(cmd_byte_i)))
        else $error("bias write lost");
    a_mux_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_WDATA && cmd_take && r.addr == BMC_ADDR_MUX_CONTROL_ONE)
        |=> (r.mux_control_one == $past(cmd_byte_i[BMC_CLKSRC_BIT-1:0])))
        else $error("mux control write lost");
    a_count_byte: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_COUNT && cmd_take)
        |=> (r.count == $past(cmd_byte_i[3:0])))
        else $error("count byte not taken");
    a_read_bias: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_RDATA && cmd_take && r.addr == BMC_ADDR_BIAS)
        |=> (rd_valid_o && rd_byte_o == $past(r.bias)))
        else $error("bias read wrong");
    a_read_mux: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_RDATA && cmd_take && r.addr == BMC_ADDR_MUX_CONTROL_ONE)
        |=> (rd_valid_o && rd_byte_o == {$past(r.clk_src), $past(r.mux_control_one)}))
        else $error("mux control read wrong");
    a_write_last: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_WDATA && cmd_take && r.count == BMC_CNT_ZERO)
        |=> (r.state == BMC_IDLE))
        else $error("write did not stop after last byte");
    a_read_last: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_RDATA && cmd_take && r.count == BMC_CNT_ZERO)
        |=> (r.state == BMC_IDLE))
        else $error("read did not stop after last byte");
    a_other_drop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state == BMC_WDATA && cmd_take && r.addr != BMC_ADDR_BIAS && r.addr != BMC_ADDR_MUX_CONTROL_ONE)
        |=> (r.bias == $past(r.bias) && r.mux_control_one == $past(r.mux_control_one)))
        else $error("write to foreign address landed");
    a_bias_zero_bits: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1
        |-> ((bias_en_o & ~r.bias) == 8'h00))
        else $error("bias on an input whose enable is zero");
    a_flag_reset: assert property (@(posedge sys_clk_i)
        sys_rst_i
        |=> (r.clk_src == 1'b0))
        else $error("clock flag not cleared by reset");
    a_idle_no_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (r.state != BMC_RDATA)
        |=> !rd_valid_o)
        else $error("read strobe outside a read");
    a_addr_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ((r.state == BMC_WDATA || r.state == BMC_RDATA) && cmd_take)
        |=> (r.addr == 4'($past(r.addr) + 4'h1)))
        else $error("address did not advance");
endmodule : bmc_regs

// [testbench/bmc_host.sv]
// host model: serial front end sending command byte streams
`timescale 1ns/100ps
module bmc_host
    import bmc_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // command byte stream
    output logic [7:0] cmd_byte_o,
    output logic cmd_valid_o,
    output logic cmd_end_o
);
    initial cmd_byte_o = 8'h00;
    initial cmd_valid_o = 1'b0;
    initial cmd_end_o = 1'b0;
    task automatic put(input logic [7:0] b);
        @(posedge sys_clk_i);
        #1;
        cmd_byte_o <= b;
        cmd_valid_o <= 1'b1;
    endtask : put
    // opcode and start address, count minus one, then the data bytes
    task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [7:0] d[$]);
        put({op, a});
        put({BMC_UPPER_ZERO, 4'(d.size() - 1)});
        foreach (d[i]) put(d[i]);
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o <= 1'b0;
        // a released line must not keep showing the last byte
        cmd_byte_o <= ~cmd_byte_o;
        cmd_end_o <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        cmd_end_o <= 1'b0;
    endtask : cmd
    // data byte and end in one cycle: the end wins and the byte is lost
    task automatic abort_write(input logic [3:0] a, input logic [7:0] b);
        put({BMC_WRITE_REGISTER_COMMAND_OP, a});
        put({BMC_UPPER_ZERO, 4'h0});
        @(posedge sys_clk_i);
        #1;
        cmd_byte_o <= b;
        cmd_end_o <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o <= 1'b0;
        cmd_byte_o <= ~b;
        @(posedge sys_clk_i);
        #1;
        cmd_end_o <= 1'b0;
    endtask : abort_write
endmodule : bmc_host

// [testbench/testbench.sv]
// testbench: register bank driven through the host model
`timescale 1ns/100ps
module testbench;
    import bmc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ext_clk_sel_i = 1'b0;
    logic [7:0] cmd_byte, rd_byte, bias_en;
    logic cmd_valid, cmd_end, rd_valid;
    logic [1:0] ref_ctrl, ref_sel;
    logic [2:0] mon_sel;
    logic [7:0] rd_q[$];
    int mismatches = 0;
    int n_tests = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (rd_valid === 1'b1) rd_q.push_back(rd_byte);
    bmc_host host (.sys_clk_i(sys_clk_i), .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid),
        .cmd_end_o(cmd_end));
    bmc_regs DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cmd_byte_i(cmd_byte),
        .cmd_valid_i(cmd_valid), .cmd_end_i(cmd_end), .ext_clk_sel_i(ext_clk_sel_i),
        .rd_byte_o(rd_byte), .rd_valid_o(rd_valid), .bias_en_o(bias_en),
        .ref_ctrl_o(ref_ctrl), .ref_sel_o(ref_sel), .mon_sel_o(mon_sel));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic read_back(input logic [3:0] a, input logic [7:0] e[$]);
        logic [7:0] nops[$];
        foreach (e[i]) nops.push_back(BMC_NOP);
        rd_q = {};
        host.cmd(BMC_RREG_OP, a, nops);
        check(8'(rd_q.size()), 8'(e.size()));
        foreach (e[i]) check(rd_q[i], e[i]);
    endtask : read_back
    task automatic t_reset;
        @(posedge sys_clk_i);
        #1;
        sys_rst_i <= 1'b1;
        ext_clk_sel_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        sys_rst_i <= 1'b0;
        check(bias_en, BMC_BIAS_RST);
        check({1'b0, ref_ctrl, ref_sel, mon_sel}, {1'b0, BMC_MUX_CONTROL_ONE_RST});
        read_back(BMC_ADDR_MUX_CONTROL_ONE, {8'h00});
    endtask : t_reset
    task automatic t_bias;
        host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_BIAS, {8'ha5});
        check(bias_en, 8'ha5);
        host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_BIAS, {8'h5a});
        check(bias_en, 8'h5a);
    endtask : t_bias
    task automatic t_fields;
        // two registers in one command, written bit 7 must not stick
        host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_BIAS, {8'h3c, 8'hd8});
        check(bias_en, 8'h3c);
        check({1'b0, ref_ctrl, ref_sel, mon_sel}, 8'h58);
        read_back(BMC_ADDR_BIAS, {8'h3c, 8'h58});
        ext_clk_sel_i <= 1'b1;
        // flag is sampled a cycle late, so let it settle
        repeat (2) @(posedge sys_clk_i);
        read_back(BMC_ADDR_MUX_CONTROL_ONE, {8'hd8});
        host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_MUX_CONTROL_ONE, {8'h18});
        read_back(BMC_ADDR_MUX_CONTROL_ONE, {8'h98});
    endtask : t_fields
    task automatic t_monitor;
        for (int m = 1; m < 8; m++) begin
            host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_MUX_CONTROL_ONE, {{5'h00, 3'(m)}});
            check(bias_en, 8'h00);
            check({5'h00, mon_sel}, {5'h00, 3'(m)});
        end
        host.cmd(BMC_WRITE_REGISTER_COMMAND_OP, BMC_ADDR_MUX_CONTROL_ONE, {{5'h00, BMC_MON_NORMAL}});
        check(bias_en, 8'h3c);
    endtask : t_monitor
    task automatic t_abort;
        host.abort_write(BMC_ADDR_BIAS, 8'hff);
        check(bias_en, 8'h3c);
        read_back(BMC_ADDR_BIAS, {8'h3c});
    endtask : t_abort
    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        t_reset();
        t_bias();
        t_fields();
        t_monitor();
        t_abort();
        t_reset();
        tally_and_finish();
    end
    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end
endmodule : testbench
